// [rtl/lcre_pkg.sv]
// lcre_pkg: register map, field positions and datapath types for the line-cycle energy / reactive power block.
// assumes one aclk domain; registers are one aligned 32-bit word each on axi4-lite.
package lcre_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_LINE_CYCLE_MODE = 8'h00;
  localparam logic [7:0] OFS_HALF_CYCLE_COUNT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_ENERGY_A = 8'h10;
  localparam logic [7:0] OFS_ENERGY_B = 8'h14;
  localparam logic [7:0] OFS_ENERGY_C = 8'h18;
  localparam logic [7:0] OFS_VAR_A = 8'h1C;
  localparam logic [7:0] OFS_VAR_B = 8'h20;
  localparam logic [7:0] OFS_VAR_C = 8'h24;
  localparam logic [7:0] OFS_GAIN_A = 8'h28;
  localparam logic [7:0] OFS_GAIN_B = 8'h2C;
  localparam logic [7:0] OFS_GAIN_C = 8'h30;
  localparam logic [7:0] OFS_OFFS_A = 8'h34;
  localparam logic [7:0] OFS_OFFS_B = 8'h38;
  localparam logic [7:0] OFS_OFFS_C = 8'h3C;
  localparam int unsigned BIT_ACTIVE_ENABLE = 0;
  localparam int unsigned BIT_ZX_C = 3;
  localparam int unsigned BIT_ZX_B = 4;
  localparam int unsigned BIT_ZX_A = 5;
  localparam int unsigned BIT_CLEAR_ON_READ = 6;
  localparam int unsigned BIT_DONE = 5;
  localparam logic [7:0] RST_MODE = 8'h78;
  localparam logic [15:0] RST_HALF_CYCLES = 16'hFFFF;
  localparam logic [23:0] RST_GAIN = 24'h00_0000;
  localparam logic [23:0] RST_OFFS = 24'h00_0000;
  localparam int unsigned GAIN_FRAC = 23;
  localparam int unsigned FULL_SCALE_POWER_SHIFT = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam real CLK_MHZ = 10.0;
  localparam real SAMPLE_US = 125.0;
  localparam int unsigned SAMPLE_CYCLES = int'(SAMPLE_US * CLK_MHZ);

  typedef struct packed {
    logic signed [27:0] v;
    logic signed [27:0] i_shift;
    logic signed [27:0] p_act;
  } lcre_phase_in_s;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } lcre_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lcre_axi_rsp_s;
endpackage

// [rtl/lcre_core.sv]
// lcre_core: line-cycle active energy accumulation and per-phase total reactive power datapath,
// with an axi4-lite register slave.
// assumes zero-crossing pulses and sample strobe are synchronous one-cycle pulses on aclk;
// per-phase voltage, quadrature current and active power samples are synchronous to aclk.
// Behaviour
// RULE1: line-cycle mode only when enable bit 0 set
// RULE2: copy 32-bit accumulators after half-cycle target
// RULE3: target is 16-bit unsigned, up to 65535
// RULE4: bits 5,4,3 select phases A,B,C crossings
// RULE5: host enables one phase during calibration
// RULE6: host keeps clear-on-read bit 6 low
// RULE7: zero-crossing counter always runs
// RULE8: count write while enabled resets counter
// RULE9: period end sets status bit 5, interrupt
// RULE10: write-one clears flag, interrupt released
// RULE11: same energy path as normal accumulation
// RULE12: reactive power is voltage times shifted current
// RULE13: reactive power stored in 24-bit registers
// RULE14: full scale maps to full_scale_power over sixteen
// RULE15: gain scales by one plus gain/2^23
// RULE16: 0xC00000 halves, 0x400000 adds half
// RULE17: gain read as 28-bit sign extension
// RULE18: signed 24-bit offset per phase applied
// RULE19: offset read as 28-bit sign extension
// RULE20: 8kHz accumulation, pulse, subtract threshold
// RULE21: restart count without losing pulses
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module lcre_core
  import lcre_pkg::*;
#(
  parameter int unsigned ACC_W = 48
)
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire lcre_pkg::lcre_axi_req_s axi_req, // axi4-lite master to slave
  output lcre_pkg::lcre_axi_rsp_s axi_rsp, // axi4-lite slave to master
  input wire logic sample_stb, // one-cycle 8 kHz sample strobe
  input wire logic [2:0] zero_cross, // per-phase zero-crossing pulses, [0]=A
  input wire lcre_pkg::lcre_phase_in_s [2:0] phase_in, // per-phase samples, [0]=A
  input wire logic [ACC_W-1:0] energy_threshold, // first-stage threshold, shared by phases
  output logic [2:0] energy_pulse, // one-cycle first-stage pulses
  output logic first_interrupt_out_n // interrupt, active low
);
  import lcre_pkg::*;

  logic [7:0] line_cycle_mode_q;
  logic [15:0] half_cycle_count_q;
  logic [15:0] zx_cnt_q;
  logic [31:0] status_q;
  logic [31:0] mask_q;
  logic signed [ACC_W-1:0] acc_q [3];
  logic signed [31:0] pulse_acc_q [3];
  logic signed [31:0] energy_q [3];
  logic [23:0] var_q [3];
  logic [23:0] gain_q [3];
  logic [23:0] offs_q [3];
  logic [2:0] pulse_q;
  logic [2:0] pulse_neg_q;

  // write and read channel
  logic aw_held_q;
  logic w_held_q;
  logic bvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic rd_fire;

  function automatic logic [31:0] sext28(input logic [23:0] v);
    return {4'h0, {4{v[23]}}, v}; // see RULE17 see RULE19
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  // registers are word aligned; the two low address bits are ignored
  function automatic logic [ADDR_W-1:0] word_of(input logic [ADDR_W-1:0] ad);
    return {ad[ADDR_W-1:2], 2'b00};
  endfunction

  assign axi_rsp.awready = !aw_held_q && !bvalid_q;
  assign axi_rsp.wready = !w_held_q && !bvalid_q;
  assign axi_rsp.bvalid = bvalid_q;
  assign axi_rsp.bresp = bresp_q;
  assign axi_rsp.arready = !rvalid_q;
  assign axi_rsp.rvalid = rvalid_q;
  assign axi_rsp.rdata = rdata_q;
  assign axi_rsp.rresp = rresp_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign rd_fire = axi_req.arvalid && !rvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (axi_req.awvalid && axi_rsp.awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= axi_req.awaddr;
      end
      else if (wr_fire)
        aw_held_q <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end
      else if (wr_fire)
        w_held_q <= 1'b0;
    end
  end

  logic [ADDR_W-1:0] wr_addr;
  logic wr_known;
  assign wr_addr = word_of(awaddr_q);
  // writes to the read-only words are answered OKAY and change nothing
  always_comb
  begin
    unique case (wr_addr)
      OFS_LINE_CYCLE_MODE, OFS_HALF_CYCLE_COUNT, OFS_STATUS, OFS_MASK,
      OFS_GAIN_A, OFS_GAIN_B, OFS_GAIN_C, OFS_OFFS_A, OFS_OFFS_B, OFS_OFFS_C: wr_known = 1'b1;
      OFS_ENERGY_A, OFS_ENERGY_B, OFS_ENERGY_C, OFS_VAR_A, OFS_VAR_B, OFS_VAR_C: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  // the response waits for both halves, so address and data may arrive in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (axi_req.bready)
      bvalid_q <= 1'b0;
  end

  // configuration registers
  logic wr_mode;
  logic wr_count;
  logic wr_status;
  assign wr_mode = wr_fire && (wr_addr == OFS_LINE_CYCLE_MODE);
  assign wr_count = wr_fire && (wr_addr == OFS_HALF_CYCLE_COUNT);
  assign wr_status = wr_fire && (wr_addr == OFS_STATUS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_cycle_mode_q <= RST_MODE;
      half_cycle_count_q <= RST_HALF_CYCLES;
      mask_q <= '0;
      for (int p = 0; p < 3; p++)
      begin
        gain_q[p] <= RST_GAIN;
        offs_q[p] <= RST_OFFS;
      end
    end
    else if (wr_fire)
    begin
      if (wr_mode)
        line_cycle_mode_q <= 8'(merge({24'h00_0000, line_cycle_mode_q}, wdata_q, wstrb_q));
      if (wr_count)
        half_cycle_count_q <= 16'(merge({16'h0000, half_cycle_count_q}, wdata_q, wstrb_q)); // see RULE3
      if (wr_addr == OFS_MASK)
        mask_q <= merge(mask_q, wdata_q, wstrb_q);
      for (int p = 0; p < 3; p++)
      begin
        if (wr_addr == OFS_GAIN_A + 8'(4 * p))
          gain_q[p] <= 24'(merge(sext28(gain_q[p]), wdata_q, wstrb_q));
        if (wr_addr == OFS_OFFS_A + 8'(4 * p))
          offs_q[p] <= 24'(merge(sext28(offs_q[p]), wdata_q, wstrb_q));
      end
    end
  end

  // half-line-cycle counting; the counter never stops, so the first period after enabling may be short
  logic [2:0] zx_sel;
  logic zx_hit;
  logic period_end;
  assign zx_sel = {line_cycle_mode_q[BIT_ZX_C], line_cycle_mode_q[BIT_ZX_B], line_cycle_mode_q[BIT_ZX_A]};
  // a target of zero ends a period on every selected crossing
  assign zx_hit = |(zero_cross & zx_sel); // see RULE4
  assign period_end = zx_hit && (zx_cnt_q + 16'h0001 >= half_cycle_count_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      zx_cnt_q <= '0;
    else if (wr_count && line_cycle_mode_q[BIT_ACTIVE_ENABLE])
      zx_cnt_q <= '0; // see RULE8
    else if (period_end)
      zx_cnt_q <= '0; // see RULE21
    else if (zx_hit)
      zx_cnt_q <= zx_cnt_q + 16'h0001; // see RULE7
  end

  // first-stage accumulation at the sample rate, then pulse counting into 32-bit accumulators
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pulse_q <= '0;
      pulse_neg_q <= '0;
      for (int p = 0; p < 3; p++)
        acc_q[p] <= '0;
    end
    else
    begin
      pulse_q <= '0;
      for (int p = 0; p < 3; p++)
        if (sample_stb)
        begin
          logic signed [ACC_W-1:0] s;
          s = acc_q[p] + ACC_W'(phase_in[p].p_act);
          if (s >= $signed(energy_threshold))
          begin
            acc_q[p] <= s - $signed(energy_threshold); // see RULE20
            pulse_q[p] <= 1'b1;
            pulse_neg_q[p] <= 1'b0;
          end
          else if (-s >= $signed(energy_threshold))
          begin
            acc_q[p] <= s + $signed(energy_threshold);
            pulse_q[p] <= 1'b1;
            pulse_neg_q[p] <= 1'b1;
          end
          else
            acc_q[p] <= s;
        end
    end
  end
  assign energy_pulse = pulse_q;

  logic lc_on;
  assign lc_on = line_cycle_mode_q[BIT_ACTIVE_ENABLE]; // see RULE1

  // the pulse arriving with the period end goes into the next period so no pulse is lost
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      for (int p = 0; p < 3; p++)
      begin
        pulse_acc_q[p] <= '0;
        energy_q[p] <= '0;
      end
    else
      for (int p = 0; p < 3; p++)
      begin
        logic signed [31:0] step;
        step = pulse_q[p] ? (pulse_neg_q[p] ? -32'sd1 : 32'sd1) : 32'sd0;
        if (lc_on && period_end)
        begin
          energy_q[p] <= pulse_acc_q[p]; // see RULE2 see RULE11
          pulse_acc_q[p] <= step; // see RULE21
        end
        else if (lc_on)
          pulse_acc_q[p] <= pulse_acc_q[p] + step;
        else
        begin
          pulse_acc_q[p] <= pulse_acc_q[p] + step;
          energy_q[p] <= energy_q[p] + step; // see RULE11
        end
      end
  end

  // status: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_q <= '0;
    else
    begin
      logic [31:0] clr;
      clr = wr_status ? (wdata_q & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}}) : '0;
      status_q <= status_q & ~clr; // see RULE10
      if (lc_on && period_end)
        status_q[BIT_DONE] <= 1'b1; // see RULE9
    end
  end
  // level interrupt: stays low until every enabled flag has been cleared
  assign first_interrupt_out_n = !(|(status_q & mask_q)); // see RULE9 see RULE10

  // reactive power: v times quadrature current, offset, gain, scaled by 1/16
  // the gain factor never goes below zero, so the product never flips the sign of the result
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      for (int p = 0; p < 3; p++)
        var_q[p] <= '0;
    else if (sample_stb)
      for (int p = 0; p < 3; p++)
      begin
        logic signed [55:0] prod;
        logic signed [27:0] q;
        logic signed [52:0] g;
        prod = phase_in[p].v * phase_in[p].i_shift; // see RULE12
        q = prod[54:27] + 28'($signed(offs_q[p])); // see RULE18
        g = q * $signed({1'b0, 24'h80_0000} + {{1{gain_q[p][23]}}, gain_q[p]}); // see RULE15 see RULE16
        var_q[p] <= 24'(g[52:GAIN_FRAC] >>> FULL_SCALE_POWER_SHIFT); // see RULE13 see RULE14
      end
  end

  // the 24-bit words read back sign-extended to 28 bits with the top nibble zero
  // read path; an unmapped word answers SLVERR with zero data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      unique case (word_of(axi_req.araddr))
        OFS_LINE_CYCLE_MODE: rdata_q <= {24'h00_0000, line_cycle_mode_q};
        OFS_HALF_CYCLE_COUNT: rdata_q <= {16'h0000, half_cycle_count_q};
        OFS_STATUS: rdata_q <= status_q;
        OFS_MASK: rdata_q <= mask_q;
        OFS_ENERGY_A: rdata_q <= energy_q[0];
        OFS_ENERGY_B: rdata_q <= energy_q[1];
        OFS_ENERGY_C: rdata_q <= energy_q[2];
        OFS_VAR_A: rdata_q <= sext28(var_q[0]);
        OFS_VAR_B: rdata_q <= sext28(var_q[1]);
        OFS_VAR_C: rdata_q <= sext28(var_q[2]);
        OFS_GAIN_A: rdata_q <= sext28(gain_q[0]);
        OFS_GAIN_B: rdata_q <= sext28(gain_q[1]);
        OFS_GAIN_C: rdata_q <= sext28(gain_q[2]);
        OFS_OFFS_A: rdata_q <= sext28(offs_q[0]);
        OFS_OFFS_B: rdata_q <= sext28(offs_q[1]);
        OFS_OFFS_C: rdata_q <= sext28(offs_q[2]);
        default:
        begin
          rdata_q <= '0;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end
    else if (axi_req.rready)
      rvalid_q <= 1'b0;
  end
endmodule

// [sim/lcre_core_properties.sv]
// lcre_core_properties: concurrent checks on the ports of lcre_core.
// assumes one aclk domain and a synchronous active-low aresetn.
`timescale 1ns/1ps
module lcre_core_properties
  import lcre_pkg::*;
#(
  parameter int unsigned ACC_W = 48
)
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire lcre_pkg::lcre_axi_req_s axi_req, // bus request
  input wire lcre_pkg::lcre_axi_rsp_s axi_rsp, // bus response
  input wire logic sample_stb, // sample tick
  input wire logic [2:0] zero_cross, // crossing pulses
  input wire lcre_pkg::lcre_phase_in_s [2:0] phase_in, // samples
  input wire logic [ACC_W-1:0] energy_threshold, // threshold
  input wire logic [2:0] energy_pulse, // first-stage pulses
  input wire logic first_interrupt_out_n // interrupt, active low
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_both_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_b_answer;
    ##[0:1] axi_rsp.bvalid;
  endsequence
  a_reset_quiet: assert property ($rose(aresetn) |-> !axi_rsp.bvalid && !axi_rsp.rvalid && first_interrupt_out_n)
    else $error("outputs not idle after reset");
  a_write_answer: assert property (s_both_taken |=> s_b_answer)
    else $error("write response late");
  a_write_refuse: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write accepted while response pending");
  a_bresp_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped early");
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read data late");
  a_read_refuse: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read accepted while data pending");
  a_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data changed before taken");
  a_unmapped_err: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr >= OFS_OFFS_C + 8'h04
    |=> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_pulse_cause: assert property (energy_pulse != 3'h0 |-> $past(sample_stb))
    else $error("energy pulse without sample tick");
endmodule

// [sim/test_line_cycle_energy_and_reactive_power.sv]
// test_line_cycle_energy_and_reactive_power: self-checking bench for lcre_core.
// assumes the properties checker is compiled alongside; bench drives every port itself.
`timescale 1ns/1ps
module test_line_cycle_energy_and_reactive_power;
  import lcre_pkg::*;
  localparam int THR = 1000;
  logic aclk;
  logic aresetn;
  lcre_axi_req_s axi_req;
  lcre_axi_rsp_s axi_rsp;
  logic sample_stb;
  logic [2:0] zero_cross;
  lcre_phase_in_s [2:0] phase_in;
  logic [47:0] energy_threshold;
  logic [2:0] energy_pulse;
  logic first_interrupt_out_n;
  int bad_count = 0;
  int samples_checked = 0;
  int acc_a = 0;
  int pulses_a = 0;
  int p1;
  logic [31:0] rd;
  logic [1:0] rr;
  logic [23:0] g;
  logic [23:0] gv [6];
  logic [23:0] var_exp;
  logic [7:0] a;
  lcre_core u_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .sample_stb(sample_stb), .zero_cross(zero_cross), .phase_in(phase_in), .energy_threshold(energy_threshold),
    .energy_pulse(energy_pulse), .first_interrupt_out_n(first_interrupt_out_n));
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checked %0d mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // handshakes are judged at the negedge, where sampled values are settled, then acted on at the next rise
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic ta;
    logic tw;
    logic tb;
    @(posedge aclk);
    axi_req.awaddr <= ad;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge aclk);
      ta = axi_req.awvalid && axi_rsp.awready;
      tw = axi_req.wvalid && axi_rsp.wready;
      tb = axi_rsp.bvalid;
      @(posedge aclk);
      if (ta)
        axi_req.awvalid <= 1'b0;
      if (tw)
        axi_req.wvalid <= 1'b0;
    end
    axi_req.bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] ad);
    logic ta;
    logic tr;
    @(posedge aclk);
    axi_req.araddr <= ad;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge aclk);
      ta = axi_req.arvalid && axi_rsp.arready;
      tr = axi_rsp.rvalid;
      rd = axi_rsp.rdata;
      rr = axi_rsp.rresp;
      @(posedge aclk);
      if (ta)
        axi_req.arvalid <= 1'b0;
    end
    axi_req.rready <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] ad, input logic [31:0] exp);
    rdr(ad);
    chk(nm, rd, exp);
  endtask
  task automatic smp();
    int p;
    int vv;
    int ii;
    longint q_exp;
    logic e;
    p = $urandom_range(THR - 1, 1);
    vv = $urandom_range(1048575);
    ii = $urandom_range(1048575);
    // expected reactive power: product scaled to 28 bits, plus offset, times gain, over sixteen
    q_exp = ((longint'(vv) * ii) >>> 27) + longint'($signed(gv[3]));
    var_exp = 24'((q_exp * ((longint'(1) <<< GAIN_FRAC) + longint'($signed(gv[0])))) >>> (GAIN_FRAC + FULL_SCALE_POWER_SHIFT));
    @(posedge aclk);
    phase_in[0].p_act <= 28'(p);
    phase_in[0].v <= 28'(vv);
    phase_in[0].i_shift <= 28'(ii);
    sample_stb <= 1'b1;
    @(posedge aclk);
    sample_stb <= 1'b0;
    acc_a += p;
    e = (acc_a >= THR);
    if (e)
    begin
      acc_a -= THR;
      pulses_a++;
    end
    @(negedge aclk);
    chk("pulse_a", {31'h0, energy_pulse[0]}, {31'h0, e});
  endtask
  task automatic zx(input logic [2:0] m);
    @(posedge aclk);
    zero_cross <= m;
    @(posedge aclk);
    zero_cross <= 3'h0;
  endtask
  initial
  begin
    axi_req = '0;
    sample_stb = 1'b0;
    zero_cross = 3'h0;
    phase_in = '0;
    energy_threshold = 48'(THR);
    aresetn = 1'b0;
    rd = $urandom(72626);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc("mode", OFS_LINE_CYCLE_MODE, 32'(RST_MODE));
    rc("count", OFS_HALF_CYCLE_COUNT, 32'(RST_HALF_CYCLES));
    rc("status", OFS_STATUS, 32'h0000_0000);
    rdr(8'h40);
    chk("unmapped", {30'h0, rr}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 6; i++)
    begin
      g = (i == 0) ? 24'hC0_0000 : (i == 1) ? 24'h40_0000 : 24'($urandom);
      gv[i] = g;
      a = OFS_GAIN_A + 8'(4 * i);
      wr(a, {8'h00, g});
      rc("gain_offs", a, {4'h0, {4{g[23]}}, g});
    end
    zx(3'b001);
    wr(OFS_MASK, 32'h0000_0020);
    wr(OFS_LINE_CYCLE_MODE, 32'h0000_0021);
    wr(OFS_HALF_CYCLE_COUNT, 32'h0000_0003);
    rc("count_wr", OFS_HALF_CYCLE_COUNT, 32'h0000_0003);
    repeat (4) smp();
    rdr(OFS_VAR_A);
    chk("var_pad", {28'h0, rd[31:28]}, 32'h0000_0000);
    chk("var_a", rd, {4'h0, {4{var_exp[23]}}, var_exp});
    zx(3'b110);
    zx(3'b001);
    zx(3'b001);
    rc("status_early", OFS_STATUS, 32'h0000_0000);
    zx(3'b001);
    p1 = pulses_a;
    pulses_a = 0;
    repeat (2) @(posedge aclk);
    rc("status_done", OFS_STATUS, 32'h0000_0020);
    chk("irq_low", {31'h0, first_interrupt_out_n}, 32'h0000_0000);
    rc("energy_1", OFS_ENERGY_A, 32'(p1));
    wr(OFS_STATUS, 32'h0000_0020);
    rc("status_clr", OFS_STATUS, 32'h0000_0000);
    chk("irq_high", {31'h0, first_interrupt_out_n}, 32'h0000_0001);
    repeat (6) smp();
    rc("energy_held", OFS_ENERGY_A, 32'(p1));
    repeat (3) zx(3'b001);
    repeat (2) @(posedge aclk);
    rc("energy_2", OFS_ENERGY_A, 32'(pulses_a));
    wr(OFS_MASK, 32'h0000_0000);
    wr(OFS_LINE_CYCLE_MODE, 32'h0000_0020);
    wr(OFS_STATUS, 32'h0000_0020);
    wr(OFS_HALF_CYCLE_COUNT, 32'h0000_0001);
    zx(3'b001);
    repeat (2) @(posedge aclk);
    rc("status_off", OFS_STATUS, 32'h0000_0000);
    wr(OFS_LINE_CYCLE_MODE, 32'h0000_0021);
    wr(OFS_HALF_CYCLE_COUNT, 32'h0000_0001);
    zx(3'b001);
    repeat (2) @(posedge aclk);
    rc("status_mask", OFS_STATUS, 32'h0000_0020);
    chk("irq_masked", {31'h0, first_interrupt_out_n}, 32'h0000_0001);
    wr(OFS_LINE_CYCLE_MODE, 32'h0000_0020);
    wr(OFS_STATUS, 32'h0000_0020);
    wr(OFS_HALF_CYCLE_COUNT, 32'h0000_0003);
    repeat (2) zx(3'b001);
    wr(OFS_LINE_CYCLE_MODE, 32'h0000_0021);
    zx(3'b001);
    repeat (2) @(posedge aclk);
    rc("status_free", OFS_STATUS, 32'h0000_0020);
    final_report();
  end
  initial
  begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    final_report();
  end
endmodule
bind lcre_core lcre_core_properties #(.ACC_W(ACC_W)) u_props (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .sample_stb(sample_stb), .zero_cross(zero_cross),
  .phase_in(phase_in), .energy_threshold(energy_threshold), .energy_pulse(energy_pulse),
  .first_interrupt_out_n(first_interrupt_out_n));
